// ### core/sis_standby_ctrl.sv
// sub-idle standby controller with an axi4-lite register slave
// Function
// R1: enter only in subclock mode, select 0, trigger
// R2: oscillators run, cpu and peripheral clocks gated
// R3: halt cpu, intc and main-clock peripherals
// R4: subclock or external clocked peripherals keep running
// R5: timer h1 runs only on subclock
// R6: watch timer runs only with main stopped
// R7: serial ports run on external clock, main stopped
// R8: port pin states frozen while idle
// R9: cpu state and ram kept across idle
// R10: wake on nmi, unmasked external or peripheral
// R11: interrupt wake returns to subclock mode
// R12: reset pin wake restarts in normal mode
// R13: any qualifying request wakes regardless of priority
// R14: lower priority wake stays pending, unacknowledged
// R15: higher priority or nmi wake is acknowledged
// R16: nmi branches; maskable branches only when enabled
// R17: trigger register written only after key write
// R18: select bit chooses idle versus stop
// R19: main stop bit halts main oscillator
// R20: wake detection combinational, not on gated clocks
//
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "sis_consts.svh"
module sis_standby_ctrl #(
  parameter int EXT_W = 7,
  parameter int PER_W = 8,
  parameter int PRIO_W = 3
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // wake sources
  input wire logic nmi_i,
  input wire logic [EXT_W-1:0] external_irq_inputs_i,
  input wire logic [PER_W-1:0] periph_irq_i,
  input wire logic [PRIO_W-1:0] wake_prio_i,
  // cpu context
  input wire logic irq_enabled_state_i,
  input wire logic in_service_i,
  input wire logic [PRIO_W-1:0] service_prio_i,
  // clock gate enables
  output logic main_osc_en_o,
  output logic sub_osc_en_o,
  output logic cpu_clk_en_o,
  output logic intc_clk_en_o,
  output logic main_periph_clk_en_o,
  output logic sub_periph_clk_en_o,
  output logic timer_h_unit1_en_o,
  output logic watch_timer_en_o,
  output logic clocked_serial_ports_en_o,
  // state towards the core
  output logic port_hold_o,
  output logic subclk_mode_o,
  output logic subidle_o,
  output logic stop_req_o,
  output logic wake_ack_o,
  output logic wake_pend_o,
  output logic wake_branch_o
);
  import sis_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  sis_state_e state_q; // power state
  logic [7:0] clock_q; // subclock, main stop, count clock selects
  logic kind_q; // standby kind, 0 = idle
  logic key_ok_q; // key seen, next ctrl write allowed
  logic [EXT_W-1:0] ext_mask_q; // external masks
  logic [PER_W-1:0] per_mask_q; // peripheral masks
  logic stop_req_q; // stop requested (other block)
  logic ack_q; // one-cycle acknowledge
  logic pend_q; // pending, not acknowledged
  logic branch_q; // branch to handler
  logic [1:0] wake_cnt_q; // wake count for status
  logic wake_any;
  logic wake_mask;
  logic trig_wr;
  logic higher;

  // ------------------------------------------------------------
  // axi4-lite write path
  // ------------------------------------------------------------
  logic aw_have_q;
  logic w_have_q;
  logic [11:0] aw_q;
  logic [31:0] w_q;
  logic wr_go;

  // accept each channel once, hold until response drains
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

  // capture address
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_have_q <= 1'b0;
      aw_q <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_q <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_have_q <= 1'b0;
    end
  end

  // capture data; lane 0 strobe gates the whole word, irq mask also uses lane 1
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      w_have_q <= 1'b0;
      w_q <= 32'h0000_0000;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_q <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
    end else if (wr_go) begin
      w_have_q <= 1'b0;
    end
  end

  // write response, okay for all, unmapped writes ignored
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_bvalid <= 1'b0;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  assign s_axi_bresp = 2'b00;

  // ------------------------------------------------------------
  // protected control register
  // ------------------------------------------------------------
  // key write arms exactly one following write
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      key_ok_q <= 1'b0;
    end else if (wr_go) begin
      key_ok_q <= (aw_q == `SIS_ADDR_KEY) && (w_q[7:0] == `SIS_KEY_VALUE); // R17
    end
  end

  // a runaway write without the key never triggers
  assign trig_wr = wr_go && (aw_q == `SIS_ADDR_CTRL) && key_ok_q &&
                   w_q[`SIS_CTRL_TRIG_BIT]; // R17

  // mode select and clock controls
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      kind_q <= 1'(`SIS_MODE_RST);
      clock_q <= `SIS_CLOCK_RST;
    end else if (wr_go && aw_q == `SIS_ADDR_MODE) begin
      kind_q <= w_q[`SIS_MODE_KIND_BIT];
    end else if (wr_go && aw_q == `SIS_ADDR_CLOCK) begin
      clock_q <= w_q[7:0];
    end
  end

  // interrupt masks
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_mask_q <= {EXT_W{1'b1}};
      per_mask_q <= {PER_W{1'b1}};
    end else if (wr_go && aw_q == `SIS_ADDR_IRQMASK) begin
      ext_mask_q <= w_q[EXT_W-1:0];
      per_mask_q <= w_q[8 +: PER_W];
    end
  end

  // ------------------------------------------------------------
  // wake detection
  // ------------------------------------------------------------
  sis_wake_detect #(
    .EXT_W(EXT_W),
    .PER_W(PER_W)
  ) u_wake (
    .nmi_i(nmi_i),
    .external_irq_inputs_i(external_irq_inputs_i),
    .periph_irq_i(periph_irq_i),
    .ext_mask_i(ext_mask_q),
    .per_mask_i(per_mask_q),
    .wake_o(wake_any),
    .maskable_o(wake_mask)
  ); // R20

  // nmi or higher priority than the routine in service
  assign higher = nmi_i || !in_service_i || (wake_prio_i < service_prio_i);

  // ------------------------------------------------------------
  // power state machine
  // ------------------------------------------------------------
  // reset pin lands here in normal mode through async reset
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= SIS_NORMAL; // R12
    end else begin
      unique case (state_q)
        SIS_NORMAL: begin
          if (clock_q[`SIS_CLK_SUB_BIT]) begin
            state_q <= SIS_SUBCLK;
          end
        end
        SIS_SUBCLK: begin
          if (trig_wr && !kind_q) begin
            state_q <= SIS_SUBIDLE; // R1 R18
          end else if (!clock_q[`SIS_CLK_SUB_BIT]) begin
            state_q <= SIS_NORMAL;
          end
        end
        SIS_SUBIDLE: begin
          if (wake_any) begin
            state_q <= SIS_SUBCLK; // R10 R11 R13
          end
        end
        default: state_q <= SIS_NORMAL;
      endcase
    end
  end

  // stop request when select is 1; handled by another block
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stop_req_q <= 1'b0;
    end else begin
      stop_req_q <= trig_wr && kind_q; // R18
    end
  end

  // resume outcome, one cycle at wake
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_q <= 1'b0;
      pend_q <= 1'b0;
      branch_q <= 1'b0;
    end else begin
      ack_q <= 1'b0;
      pend_q <= 1'b0;
      branch_q <= 1'b0;
      if (state_q == SIS_SUBIDLE && wake_any) begin
        ack_q <= higher; // R15
        pend_q <= !higher; // R14
        branch_q <= higher && (nmi_i || irq_enabled_state_i); // R16
      end
    end
  end

  // wake counter for status, wraps
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wake_cnt_q <= 2'h0;
    end else if (state_q == SIS_SUBIDLE && wake_any) begin
      wake_cnt_q <= wake_cnt_q + 2'h1;
    end
  end

  // ------------------------------------------------------------
  // clock gating outputs
  // ------------------------------------------------------------
  logic idle;
  logic main_stopped;
  assign idle = (state_q == SIS_SUBIDLE);
  // main stop only honoured in subclock operation
  assign main_stopped = (state_q != SIS_NORMAL) && clock_q[`SIS_CLK_MSTOP_BIT]; // R19
  assign main_osc_en_o = !main_stopped; // R2 R19
  assign sub_osc_en_o = 1'b1; // R2
  assign cpu_clk_en_o = !idle; // R2 R3 R9
  assign intc_clk_en_o = !idle; // R3
  assign main_periph_clk_en_o = !idle && !main_stopped; // R3
  assign sub_periph_clk_en_o = 1'b1; // R4
  assign timer_h_unit1_en_o = idle ? clock_q[`SIS_CLK_H1SUB_BIT] : 1'b1; // R5
  assign watch_timer_en_o = idle ? (main_stopped && clock_q[`SIS_CLK_WSUB_BIT]) : 1'b1; // R6
  assign clocked_serial_ports_en_o = idle ?
      (main_stopped && clock_q[`SIS_CLK_CSIEXT_BIT]) : 1'b1; // R7
  assign port_hold_o = idle; // R8
  assign subclk_mode_o = (state_q == SIS_SUBCLK);
  assign subidle_o = idle;
  assign stop_req_o = stop_req_q;
  assign wake_ack_o = ack_q;
  assign wake_pend_o = pend_q;
  assign wake_branch_o = branch_q;

  // ------------------------------------------------------------
  // axi4-lite read path
  // ------------------------------------------------------------
  logic [31:0] rd_mux;
  assign s_axi_arready = !s_axi_rvalid;
  // decode, unmapped reads return zero with okay
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (s_axi_araddr)
      `SIS_ADDR_CTRL: rd_mux = 32'h0000_0000;
      `SIS_ADDR_MODE: rd_mux = {31'h0, kind_q};
      `SIS_ADDR_CLOCK: rd_mux = {24'h0, clock_q};
      `SIS_ADDR_KEY: rd_mux = {31'h0, key_ok_q};
      `SIS_ADDR_STATUS: rd_mux = {28'h0, wake_cnt_q, state_q};
      `SIS_ADDR_WAKE: rd_mux = {16'h0, 8'(periph_irq_i), 7'(external_irq_inputs_i), nmi_i};
      `SIS_ADDR_IRQMASK: rd_mux = {16'h0, 8'(per_mask_q), 1'b0, 7'(ext_mask_q)};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data register
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_rresp = 2'b00;
endmodule // sis_standby_ctrl

// ### core/sis_consts.svh
// constants for the sub-idle standby controller
`ifndef SIS_CONSTS_SVH
`define SIS_CONSTS_SVH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define SIS_ADDR_CTRL 12'h000
`define SIS_ADDR_MODE 12'h004
`define SIS_ADDR_CLOCK 12'h008
`define SIS_ADDR_KEY 12'h00c
`define SIS_ADDR_STATUS 12'h010
`define SIS_ADDR_WAKE 12'h014
`define SIS_ADDR_IRQMASK 12'h018

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define SIS_CTRL_TRIG_BIT 1
`define SIS_MODE_KIND_BIT 0
`define SIS_CLK_SUB_BIT 0
`define SIS_CLK_MSTOP_BIT 1
`define SIS_CLK_H1SUB_BIT 2
`define SIS_CLK_WSUB_BIT 3
`define SIS_CLK_CSIEXT_BIT 4

// ------------------------------------------------------------
// reset values and keys
// ------------------------------------------------------------
`define SIS_CTRL_RST 8'h00
`define SIS_MODE_RST 8'h01
`define SIS_CLOCK_RST 8'h00
`define SIS_KEY_VALUE 8'ha5
`define SIS_IRQMASK_RST 8'hff

`endif

// ### core/sis_pkg.sv
// types for the sub-idle standby controller
package sis_pkg;
  // power state of the device
  typedef enum logic [1:0] {
    SIS_NORMAL,
    SIS_SUBCLK,
    SIS_SUBIDLE
  } sis_state_e;

  // how the core resumes after a wake
  typedef enum logic [1:0] {
    SIS_RES_NEXT,
    SIS_RES_BRANCH,
    SIS_RES_PEND
  } sis_resume_e;
endpackage

// ### core/sis_wake_detect.sv
// combinational wake request detector
`timescale 1ns/100ps
module sis_wake_detect #(
  parameter int EXT_W = 7,
  parameter int PER_W = 8
) (
  // request sources
  input wire logic nmi_i,
  input wire logic [EXT_W-1:0] external_irq_inputs_i,
  input wire logic [PER_W-1:0] periph_irq_i,
  // masks, 1 = masked
  input wire logic [EXT_W-1:0] ext_mask_i,
  input wire logic [PER_W-1:0] per_mask_i,
  // results
  output logic wake_o,
  output logic maskable_o
);
  // no clock here: the gated clocks are stopped while idle
  always_comb begin
    maskable_o = |(external_irq_inputs_i & ~ext_mask_i) | |(periph_irq_i & ~per_mask_i); // R10
    wake_o = nmi_i | maskable_o; // R13 R20
  end
endmodule // sis_wake_detect

// ### verification/sis_standby_ctrl_assertions.sv
// port checker for the sub-idle standby controller
`timescale 1ns/100ps
module sis_chk (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // wake source
  input wire logic nmi_i,
  // clock gates
  input wire logic main_osc_en_o,
  input wire logic sub_osc_en_o,
  input wire logic cpu_clk_en_o,
  input wire logic intc_clk_en_o,
  input wire logic main_periph_clk_en_o,
  input wire logic sub_periph_clk_en_o,
  input wire logic watch_timer_en_o,
  input wire logic clocked_serial_ports_en_o,
  // state and wake pulses
  input wire logic port_hold_o,
  input wire logic subclk_mode_o,
  input wire logic subidle_o,
  input wire logic wake_ack_o,
  input wire logic wake_pend_o,
  input wire logic wake_branch_o
);
  // ----------------------------------------
  // one clock domain, reset pin disables all
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  // non-maskable request seen while idle
  sequence wake_s; subidle_o && nmi_i; endsequence
  // back in subclock mode with the request taken
  sequence exit_s; !subidle_o && subclk_mode_o && wake_ack_o && wake_branch_o; endsequence

  gate_off_a: assert property (subidle_o |-> !(cpu_clk_en_o | intc_clk_en_o))
    else $error("core clocks running while idle");
  periph_off_a: assert property (subidle_o |-> !main_periph_clk_en_o)
    else $error("main peripheral clock running while idle");
  keep_sub_a: assert property (subidle_o |-> port_hold_o && sub_osc_en_o && sub_periph_clk_en_o)
    else $error("pins or subclock lost while idle");
  watch_stop_a: assert property (subidle_o && main_osc_en_o |->
    !watch_timer_en_o && !clocked_serial_ports_en_o)
    else $error("watch or serial runs with main clock on");
  entry_only_a: assert property ($rose(subidle_o) |-> $past(subclk_mode_o))
    else $error("idle entered outside subclock mode");
  nmi_wake_a: assert property (wake_s |=> exit_s)
    else $error("nmi did not wake and get taken");
  resume_sub_a: assert property ($fell(subidle_o) |-> subclk_mode_o && (wake_ack_o ^ wake_pend_o))
    else $error("wake exit wrong mode or ack state");
  branch_ack_a: assert property (wake_branch_o |-> wake_ack_o)
    else $error("branch without acknowledge");
endmodule // sis_chk

// ### verification/sis_cpu_model.sv
// cpu and interrupt controller context seen by the controller
`timescale 1ns/100ps
module sis_cpu_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // context from bench: en, in service, service prio, wake prio
  input wire logic [7:0] ctx_i,
  // wake outcome
  input wire logic wake_ack_i,
  input wire logic wake_pend_i,
  // context towards the controller
  output logic irq_enabled_state_o,
  output logic in_service_o,
  output logic [2:0] service_prio_o,
  output logic [2:0] wake_prio_o,
  // request still held by the controller model
  output logic pend_o
);
  // context only changes at an edge, as a real core would
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {irq_enabled_state_o, in_service_o, service_prio_o, wake_prio_o} <= 8'h00;
    end else begin
      {irq_enabled_state_o, in_service_o, service_prio_o, wake_prio_o} <= ctx_i;
    end
  end
  // a pended request is kept until some later wake is taken
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pend_o <= 1'b0;
    end else if (wake_ack_i) begin
      pend_o <= 1'b0;
    end else if (wake_pend_i) begin
      pend_o <= 1'b1;
    end
  end
endmodule // sis_cpu_model

// ### verification/test_sub_idle_standby_control.sv
// self-checking bench for the sub-idle standby controller
`timescale 1ns/100ps
module test_sub_idle_standby_control;
  // bus, sources and observed outputs
  logic clk = 0, rstn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd, rdata;
  logic nmi = 0;
  logic [6:0] ext = 0;
  logic [7:0] per = 0, ctx = 0;
  logic awready, wready, bvalid, arready, rvalid, ien, svc, pend, mosc, sosc, cpuen, intcen;
  logic mpen, spen, h1en, wten, csien, hold, subm, sidle, stopr, ack, pnd, br;
  logic [1:0] bresp, rresp;
  logic [2:0] sprio, wprio;
  int bad_count = 0, tests_run = 0, cyc = 0, n_ack = 0, n_pend = 0, n_br = 0, n_stop = 0;
  int a, p, b;
  bit nm, eack;
  logic [11:0] adr [5] = '{12'h000, 12'h004, 12'h008, 12'h010, 12'h100};
  logic [31:0] rst_v [5] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0};

  always #4 clk = ~clk;

  sis_standby_ctrl uut (.ref_clk_i(clk), .resetn_i(rstn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .nmi_i(nmi),
    .external_irq_inputs_i(ext), .periph_irq_i(per), .wake_prio_i(wprio),
    .irq_enabled_state_i(ien), .in_service_i(svc), .service_prio_i(sprio),
    .main_osc_en_o(mosc), .sub_osc_en_o(sosc), .cpu_clk_en_o(cpuen), .intc_clk_en_o(intcen),
    .main_periph_clk_en_o(mpen), .sub_periph_clk_en_o(spen), .timer_h_unit1_en_o(h1en),
    .watch_timer_en_o(wten), .clocked_serial_ports_en_o(csien), .port_hold_o(hold),
    .subclk_mode_o(subm), .subidle_o(sidle), .stop_req_o(stopr), .wake_ack_o(ack),
    .wake_pend_o(pnd), .wake_branch_o(br));

  sis_cpu_model u_cpu (.ref_clk_i(clk), .resetn_i(rstn), .ctx_i(ctx), .wake_ack_i(ack),
    .wake_pend_i(pnd), .irq_enabled_state_o(ien), .in_service_o(svc),
    .service_prio_o(sprio), .wake_prio_o(wprio), .pend_o(pend));

  // pulse counters and hang guard
  always @(posedge clk) begin
    cyc++;
    n_ack += ack;
    n_pend += pnd;
    n_br += br;
    n_stop += stopr;
    if (cyc == 5000) begin
      bad_count++;
      final_report;
    end
  end

  task chk(input string nm_s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm_s, e, g);
    end
  endtask

  // write: offer both channels, release each when taken, then the response
  task wr(input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk);
    awaddr <= ad; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge clk);
    chk("bresp", 0, bresp);
    bready <= 0;
  endtask

  task rdr(input logic [11:0] ad, output logic [31:0] d);
    @(posedge clk);
    araddr <= ad; arvalid <= 1; rready <= 1;
    do @(posedge clk); while (!arready);
    arvalid <= 0;
    while (!rvalid) @(posedge clk);
    d = rdata;
    chk("rresp", 0, rresp);
    rready <= 0;
  endtask

  // key then trigger, as software must
  task enter;
    wr(12'h00c, 32'ha5);
    wr(12'h000, 32'h2);
    @(posedge clk);
    #1;
  endtask

  task final_report;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    rd = $urandom(68);
    repeat (3) @(posedge clk);
    rstn <= 1;
    for (int i = 0; i < 5; i++) begin
      rdr(adr[i], rd);
      chk("reset value", rst_v[i], rd);
    end
    wr(12'h008, 32'h1);
    wr(12'h000, 32'h2);
    rdr(12'h010, rd);
    chk("trigger without key", 1, rd & 32'h3);
    a = n_stop;
    enter;
    chk("stop request", a + 1, n_stop);
    chk("no idle on stop", 0, sidle);
    wr(12'h008, 32'h0);
    rdr(12'h010, rd);
    chk("back to normal", 0, rd & 32'h3);
    wr(12'h004, 32'h0);
    enter;
    chk("no idle in normal", 0, sidle);
    wr(12'h008, 32'h5);
    wr(12'h018, 32'hfefe);
    rdr(12'h018, rd);
    chk("irq mask", 32'hfe7e, rd);
    for (int i = 0; i < 6; i++) begin
      ctx <= 8'($urandom);
      enter;
      chk("idle", 1, sidle);
      chk("cpu clock", 0, cpuen);
      chk("pins held", 1, hold);
      chk("intc clock", 0, intcen);
      chk("main periph clock", 0, mpen);
      chk("sub periph clock", 1, spen);
      chk("sub oscillator", 1, sosc);
      chk("timer h1 on sub", 1, h1en);
      chk("watch timer off", 0, wten);
      chk("serial off", 0, csien);
      a = n_ack; p = n_pend; b = n_br;
      if (i % 3 == 1) begin
        ext <= 7'h2;
        repeat (8) @(posedge clk);
        chk("masked source", 1, sidle);
        rdr(12'h014, rd);
        chk("wake inputs", 32'h4, rd);
      end
      nm = (i % 3 == 0);
      nmi <= nm;
      ext <= (i % 3 == 1) ? 7'h3 : 7'h0;
      per <= (i % 3 == 2) ? 8'h1 : 8'h0;
      while (sidle) @(posedge clk);
      @(posedge clk);
      #1;
      eack = nm || !ctx[6] || (ctx[2:0] < ctx[5:3]);
      chk("ack", a + eack, n_ack);
      chk("pend", p + !eack, n_pend);
      chk("branch", b + (eack && (nm || ctx[7])), n_br);
      chk("resume mode", 1, subm);
      chk("held request", !eack, pend);
      nmi <= 0; ext <= 0; per <= 0;
    end
    wr(12'h008, 32'h1b);
    @(posedge clk);
    #1;
    chk("main osc", 0, mosc);
    enter;
    chk("watch timer", 1, wten);
    chk("serial ext", 1, csien);
    chk("timer h1", 0, h1en);
    rstn <= 0;
    repeat (3) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    #1;
    chk("reset to normal", 0, subm);
    chk("reset ends idle", 0, sidle);
    chk("osc restarts", 1, mosc);
    final_report;
  end
endmodule // test_sub_idle_standby_control

bind sis_standby_ctrl sis_chk u_chk (.ref_clk_i, .resetn_i, .nmi_i, .main_osc_en_o,
  .sub_osc_en_o, .cpu_clk_en_o, .intc_clk_en_o, .main_periph_clk_en_o, .sub_periph_clk_en_o,
  .watch_timer_en_o, .clocked_serial_ports_en_o, .port_hold_o, .subclk_mode_o, .subidle_o,
  .wake_ack_o, .wake_pend_o, .wake_branch_o);
